// ==== inc/mhr_pkg.sv ====
// constants and types for the mute, hook and ring configuration bank
package mhr_pkg;

	// register word indices; byte address is four times the index
	localparam logic [9:0] IDX_GAIN  = 10'h00f;
	localparam logic [9:0] IDX_LINE  = 10'h010;
	localparam logic [9:0] IDX_LINE2 = 10'h011;
	localparam logic [9:0] IDX_HOOK  = 10'h020;
	localparam logic [9:0] IDX_STAT  = 10'h021;

	localparam logic [7:0] RESET_VAL = 8'h00;

	// gain and mute control fields
	localparam int GAIN_TXM_BIT = 7;
	localparam int GAIN_RXM_BIT = 3;
	localparam logic [7:0] GAIN_WMASK = 8'h88;

	// line interface control fields; bits 7 and 5 take any value and store none
	localparam int LINE_OHS_BIT = 6;
	localparam int LINE_IIR_BIT = 4;
	localparam int LINE_RZ_BIT  = 1;
	localparam int LINE_RT_BIT  = 0;
	localparam logic [7:0] LINE_WMASK = 8'h53;

	// second line interface register, only the high threshold bit is held here
	localparam int LINE2_RT2_BIT = 4;
	localparam logic [7:0] LINE2_WMASK = 8'h10;

	// hook control fields
	localparam int HOOK_OH_BIT  = 0;
	localparam int HOOK_EXT_BIT = 1;
	localparam int HOOK_SQ_LSB  = 2;
	localparam logic [7:0] HOOK_WMASK = 8'h0f;
	localparam logic [1:0] SQ_SPARK   = 2'h3;

	// status fields
	localparam int STAT_HOLD_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_RSV_BIT  = 2;

	// ring detect window in millivolts rms, code is {lo bit, hi bit}
	localparam logic [1:0]  RT_CODE_LOW  = 2'h0;
	localparam logic [1:0]  RT_CODE_RSV  = 2'h1;
	localparam logic [1:0]  RT_CODE_MID  = 2'h2;
	localparam logic [1:0]  RT_CODE_HIGH = 2'h3;
	localparam logic [15:0] RT_LOW_LO_MV  = 16'd13500;
	localparam logic [15:0] RT_LOW_HI_MV  = 16'd16500;
	localparam logic [15:0] RT_MID_LO_MV  = 16'd19350;
	localparam logic [15:0] RT_MID_HI_MV  = 16'd23650;
	localparam logic [15:0] RT_HIGH_LO_MV = 16'd40500;
	localparam logic [15:0] RT_HIGH_HI_MV = 16'd49500;

	// on-hook release times
	localparam int CLK_PERIOD_NS    = 8;
	localparam int REL_FAST_MAX_NS  = 500000;
	localparam int REL_ETSI_NS      = 3000000;
	localparam int REL_SPARK_NS     = 26000000;
	localparam int REL_FAST_CYC     = REL_FAST_MAX_NS / CLK_PERIOD_NS - 1;
	localparam int REL_ETSI_CYC     = REL_ETSI_NS / CLK_PERIOD_NS;
	localparam int REL_SPARK_CYC    = REL_SPARK_NS / CLK_PERIOD_NS;
	localparam int REL_CNT_W        = 23;

	typedef enum logic [1:0] {
		REL_FAST,
		REL_ETSI,
		REL_SPARK
	} mhr_rel_t;

endpackage

// ==== hdl/mhr_release_timer.sv ====
// on-hook release timer holding loop current after the off-hook bit clears
`timescale 1ns/1ps

module mhr_release_timer #(
	parameter int FAST_CYC  = mhr_pkg::REL_FAST_CYC,
	parameter int ETSI_CYC  = mhr_pkg::REL_ETSI_CYC,
	parameter int SPARK_CYC = mhr_pkg::REL_SPARK_CYC
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             offhook_ctl,
	input  wire mhr_pkg::mhr_rel_t rel_sel,
	output logic                  loop_hold,
	output logic                  release_busy
);

	typedef enum logic [1:0] {
		ST_ONHOOK,
		ST_OFFHOOK,
		ST_RELEASE
	} mhr_tmr_state_t;

	localparam int W = mhr_pkg::REL_CNT_W;

	mhr_tmr_state_t       state;
	mhr_tmr_state_t       next_state;
	logic [W-1:0]         cnt;
	logic [W-1:0]         next_cnt;
	logic                 next_loop_hold;
	logic                 next_release_busy;
	logic [W-1:0]         load_val;

	always_comb begin
		case (rel_sel)
			mhr_pkg::REL_SPARK: load_val = W'(SPARK_CYC);
			mhr_pkg::REL_ETSI:  load_val = W'(ETSI_CYC);
			default:            load_val = W'(FAST_CYC);
		endcase
		if (load_val == '0) begin
			load_val = W'(1);
		end
	end

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			ST_ONHOOK: begin
				if (offhook_ctl) begin
					next_state = ST_OFFHOOK;
				end
			end
			ST_OFFHOOK: begin
				// timing starts when the off-hook bit is seen cleared
				if (!offhook_ctl) begin // [R4]
					next_state = ST_RELEASE;
					next_cnt   = load_val; // [R3]
				end
			end
			ST_RELEASE: begin
				if (offhook_ctl) begin
					next_state = ST_OFFHOOK;
				end else if (cnt <= W'(1)) begin
					next_state = ST_ONHOOK;
					next_cnt   = '0;
				end else begin
					next_cnt = cnt - W'(1); // [R4]
				end
			end
			default: begin
				next_state = ST_ONHOOK;
				next_cnt   = '0;
			end
		endcase
		next_loop_hold    = (next_state != ST_ONHOOK);
		next_release_busy = (next_state == ST_RELEASE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state        <= ST_ONHOOK;
			cnt          <= '0;
			loop_hold    <= 1'b0;
			release_busy <= 1'b0;
		end else begin
			state        <= next_state;
			cnt          <= next_cnt;
			loop_hold    <= next_loop_hold;
			release_busy <= next_release_busy;
		end
	end

endmodule // mhr_release_timer

// ==== hdl/mhr_config_regs.sv ====
// APB register bank for mute, hook release, filter and ring settings
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps

// How it works
// [R1] transmit mute bit high silences the transmit path, low passes it
// [R2] receive mute bit high silences the receive path, low passes it
// [R3] speed bit, extended speed bit and quench field choose the on-hook release time
// [R4] release time runs from off-hook bit clearing until loop current is dropped
// [R5] bits 7 and 5 of line control accept any value and change nothing
// [R6] filter select low means FIR on both paths, high means IIR on both
// [R7] ringer impedance bit low gives high impedance, high gives synthesized impedance
// [R8] two threshold bits set the ring detect lower and upper levels
// [R9] software must not program low bit zero with high bit one
// [R10] high threshold bit sits at bit 4 of the second line register, read/write
// [R11] registers reset to zero, reserved bits read zero and ignore writes
module mhr_config_regs #(
	parameter int REL_FAST_CYC  = mhr_pkg::REL_FAST_CYC,
	parameter int REL_ETSI_CYC  = mhr_pkg::REL_ETSI_CYC,
	parameter int REL_SPARK_CYC = mhr_pkg::REL_SPARK_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             tx_mute,
	output logic             rx_mute,
	output logic             iir_filter_sel,
	output logic             ringer_synth_sel,
	output logic      [15:0] ring_lower_mv,
	output logic      [15:0] ring_upper_mv,
	output logic             loop_hold,
	output logic             release_busy
);

	logic [7:0]        gain;
	logic [7:0]        line;
	logic [7:0]        line2;
	logic [7:0]        hook;
	logic [7:0]        next_gain;
	logic [7:0]        next_line;
	logic [7:0]        next_line2;
	logic [7:0]        next_hook;
	logic [31:0]       next_prdata;
	logic              next_pready;
	logic              next_pslverr;
	logic [15:0]       next_ring_lower_mv;
	logic [15:0]       next_ring_upper_mv;
	logic              thr_reserved;
	logic              next_thr_reserved;
	logic              hit_gain;
	logic              hit_line;
	logic              hit_line2;
	logic              hit_hook;
	logic              hit_stat;
	logic              mapped;
	logic              wr_go;
	logic [7:0]        wbyte;
	logic [7:0]        rd_byte;
	logic [1:0]        rt_code;
	mhr_pkg::mhr_rel_t rel_sel;

	// address decode
	always_comb begin
		hit_gain  = (paddr[11:2] == mhr_pkg::IDX_GAIN);
		hit_line  = (paddr[11:2] == mhr_pkg::IDX_LINE);
		hit_line2 = (paddr[11:2] == mhr_pkg::IDX_LINE2);
		hit_hook  = (paddr[11:2] == mhr_pkg::IDX_HOOK);
		hit_stat  = (paddr[11:2] == mhr_pkg::IDX_STAT);
		mapped    = (paddr[1:0] == 2'h0)
			&& (hit_gain || hit_line || hit_line2 || hit_hook || hit_stat);
		wbyte     = pwdata[7:0];
		wr_go     = psel && penable && pready && pwrite && pstrb[0] && mapped;
	end

	// read mux, reserved bits come back as zero
	always_comb begin
		rd_byte = 8'h00;
		if (hit_gain) begin
			rd_byte = gain;
		end else if (hit_line) begin
			rd_byte = line;
		end else if (hit_line2) begin
			rd_byte = line2; // [R10]
		end else if (hit_hook) begin
			rd_byte = hook;
		end else if (hit_stat) begin
			rd_byte[mhr_pkg::STAT_HOLD_BIT] = loop_hold;
			rd_byte[mhr_pkg::STAT_BUSY_BIT] = release_busy;
			rd_byte[mhr_pkg::STAT_RSV_BIT]  = thr_reserved;
		end
	end

	// one wait-free access phase; answer is prepared in the setup cycle
	always_comb begin
		next_pready  = psel && !penable;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0000_0000;
		if (psel && !penable) begin
			next_pslverr = !mapped;
			if (mapped && !pwrite) begin
				next_prdata = {24'h00_0000, rd_byte};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// register writes, only writable bits are stored
	always_comb begin
		next_gain  = gain;
		next_line  = line;
		next_line2 = line2;
		next_hook  = hook;
		if (wr_go && hit_gain) begin
			next_gain = wbyte & mhr_pkg::GAIN_WMASK; // [R11]
		end
		if (wr_go && hit_line) begin
			// bits 7 and 5 are dropped without effect
			next_line = wbyte & mhr_pkg::LINE_WMASK; // [R5]
		end
		if (wr_go && hit_line2) begin
			next_line2 = wbyte & mhr_pkg::LINE2_WMASK; // [R10]
		end
		if (wr_go && hit_hook) begin
			next_hook = wbyte & mhr_pkg::HOOK_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain  <= mhr_pkg::RESET_VAL; // [R11]
			line  <= mhr_pkg::RESET_VAL;
			line2 <= mhr_pkg::RESET_VAL;
			hook  <= mhr_pkg::RESET_VAL;
		end else begin
			gain  <= next_gain;
			line  <= next_line;
			line2 <= next_line2;
			hook  <= next_hook;
		end
	end

	// control outputs come straight from the stored bits
	always_comb begin
		tx_mute          = gain[mhr_pkg::GAIN_TXM_BIT]; // [R1]
		rx_mute          = gain[mhr_pkg::GAIN_RXM_BIT]; // [R2]
		iir_filter_sel   = line[mhr_pkg::LINE_IIR_BIT]; // [R6]
		ringer_synth_sel = line[mhr_pkg::LINE_RZ_BIT]; // [R7]
	end

	// ring detect window; reserved code keeps the last valid window
	always_comb begin
		rt_code            = {line[mhr_pkg::LINE_RT_BIT], line2[mhr_pkg::LINE2_RT2_BIT]};
		next_ring_lower_mv = ring_lower_mv;
		next_ring_upper_mv = ring_upper_mv;
		next_thr_reserved  = 1'b0;
		case (rt_code)
			mhr_pkg::RT_CODE_LOW: begin
				next_ring_lower_mv = mhr_pkg::RT_LOW_LO_MV; // [R8]
				next_ring_upper_mv = mhr_pkg::RT_LOW_HI_MV;
			end
			mhr_pkg::RT_CODE_MID: begin
				next_ring_lower_mv = mhr_pkg::RT_MID_LO_MV; // [R8]
				next_ring_upper_mv = mhr_pkg::RT_MID_HI_MV;
			end
			mhr_pkg::RT_CODE_HIGH: begin
				next_ring_lower_mv = mhr_pkg::RT_HIGH_LO_MV; // [R8]
				next_ring_upper_mv = mhr_pkg::RT_HIGH_HI_MV;
			end
			default: begin
				next_thr_reserved = 1'b1; // [R9]
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_lower_mv <= mhr_pkg::RT_LOW_LO_MV;
			ring_upper_mv <= mhr_pkg::RT_LOW_HI_MV;
			thr_reserved  <= 1'b0;
		end else begin
			ring_lower_mv <= next_ring_lower_mv;
			ring_upper_mv <= next_ring_upper_mv;
			thr_reserved  <= next_thr_reserved;
		end
	end

	// release speed choice from speed, extended speed and quench bits
	always_comb begin
		if (line[mhr_pkg::LINE_OHS_BIT]
			&& hook[mhr_pkg::HOOK_SQ_LSB+1:mhr_pkg::HOOK_SQ_LSB] == mhr_pkg::SQ_SPARK) begin
			rel_sel = mhr_pkg::REL_SPARK; // [R3]
		end else if (line[mhr_pkg::LINE_OHS_BIT] || hook[mhr_pkg::HOOK_EXT_BIT]) begin
			rel_sel = mhr_pkg::REL_ETSI; // [R3]
		end else begin
			rel_sel = mhr_pkg::REL_FAST;
		end
	end

	mhr_release_timer #(
		.FAST_CYC  (REL_FAST_CYC),
		.ETSI_CYC  (REL_ETSI_CYC),
		.SPARK_CYC (REL_SPARK_CYC)
	) u_release (
		.pclk         (pclk),
		.presetn      (presetn),
		.offhook_ctl  (hook[mhr_pkg::HOOK_OH_BIT]), // [R4]
		.rel_sel      (rel_sel),
		.loop_hold    (loop_hold),
		.release_busy (release_busy)
	);

endmodule // mhr_config_regs

// ==== tb/mhr_config_regs_properties.sv ====
// port checker for the configuration register bank
`timescale 1ns/1ps

module mhr_config_regs_properties #(
	parameter int REL_FAST_CYC  = mhr_pkg::REL_FAST_CYC,
	parameter int REL_ETSI_CYC  = mhr_pkg::REL_ETSI_CYC,
	parameter int REL_SPARK_CYC = mhr_pkg::REL_SPARK_CYC
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tx_mute,
	input wire logic        rx_mute,
	input wire logic        iir_filter_sel,
	input wire logic        ringer_synth_sel,
	input wire logic [15:0] ring_lower_mv,
	input wire logic [15:0] ring_upper_mv,
	input wire logic        loop_hold,
	input wire logic        release_busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_ok;
	logic rd_ok;
	assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
	assign rd_ok = psel && penable && pready && !pwrite;

	a_tx_mute_follow: assert property (wr_ok && paddr == 12'h03c |=>
		tx_mute == $past(pwdata[7])) else $error("tx mute not taken from write");
	a_rx_mute_follow: assert property (wr_ok && paddr == 12'h03c |=>
		rx_mute == $past(pwdata[3])) else $error("rx mute not taken from write");
	a_iir_sel_follow: assert property (wr_ok && paddr == 12'h040 |=>
		iir_filter_sel == $past(pwdata[4])) else $error("filter select wrong");
	a_ringer_sel_follow: assert property (wr_ok && paddr == 12'h040 |=>
		ringer_synth_sel == $past(pwdata[1])) else $error("ringer select wrong");
	a_ring_window_legal: assert property ((ring_lower_mv == 16'd13500
		&& ring_upper_mv == 16'd16500) || (ring_lower_mv == 16'd19350
		&& ring_upper_mv == 16'd23650) || (ring_lower_mv == 16'd40500
		&& ring_upper_mv == 16'd49500)) else $error("ring window not a legal pair");
	a_gain_rsv_zero: assert property (rd_ok && paddr == 12'h03c |->
		(prdata & 32'hffffff77) == 32'h0) else $error("gain reserved bits set");
	a_line_rsv_zero: assert property (rd_ok && paddr == 12'h040 |->
		(prdata & 32'hffffffac) == 32'h0) else $error("line reserved bits set");
	a_line2_rsv_zero: assert property (rd_ok && paddr == 12'h044 |->
		(prdata & 32'hffffffef) == 32'h0) else $error("line2 reserved bits set");
	a_release_holds_loop: assert property (release_busy |-> loop_hold)
		else $error("loop dropped while release timing");
	a_loop_drop_after: assert property ($fell(loop_hold) |-> $past(release_busy))
		else $error("loop dropped without release timing");
endmodule // mhr_config_regs_properties

bind mhr_config_regs mhr_config_regs_properties #(.REL_FAST_CYC(REL_FAST_CYC),
	.REL_ETSI_CYC(REL_ETSI_CYC), .REL_SPARK_CYC(REL_SPARK_CYC)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_mute(tx_mute), .rx_mute(rx_mute),
	.iir_filter_sel(iir_filter_sel), .ringer_synth_sel(ringer_synth_sel),
	.ring_lower_mv(ring_lower_mv), .ring_upper_mv(ring_upper_mv),
	.loop_hold(loop_hold), .release_busy(release_busy));

// ==== tb/test_mhr_config_regs.sv ====
// self-checking bench for the configuration register bank
`timescale 1ns/1ps

module test_mhr_config_regs;
	localparam int FAST = 3;
	localparam int ETSI = 10;
	localparam int SPARK = 20;
	localparam logic [15:0] LO_MV [3] = '{16'd13500, 16'd19350, 16'd40500};
	localparam logic [15:0] HI_MV [3] = '{16'd16500, 16'd23650, 16'd49500};
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx_mute;
	logic        rx_mute;
	logic        iir_sel;
	logic        synth_sel;
	logic [15:0] lo_mv;
	logic [15:0] hi_mv;
	logic        loop_hold;
	logic        busy;
	logic [31:0] rd;
	logic        err;
	int          n_fail;
	int          cmp_count;
	int          tick;
	int          cyc;
	int          n_exp;
	int          n_busy;

	mhr_config_regs #(.REL_FAST_CYC(FAST), .REL_ETSI_CYC(ETSI), .REL_SPARK_CYC(SPARK)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_mute(tx_mute), .rx_mute(rx_mute), .iir_filter_sel(iir_sel),
		.ringer_synth_sel(synth_sel), .ring_lower_mv(lo_mv), .ring_upper_mv(hi_mv),
		.loop_hold(loop_hold), .release_busy(busy));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		tick++;
		if (tick > 5000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; the answer is taken at the edge that sees pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= {3'h0, s};
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends a hang here
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 1'b1);
	endtask

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00, 1'b1);
		chk(what, rd, exp);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		n_fail = 0;
		cmp_count = 0;
		tick = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdc("gain reset", 12'h03c, 32'h0);
		rdc("line reset", 12'h040, 32'h0);
		chk("ring lower reset", lo_mv, 32'd13500);
		$display("reset test done");
		wr(12'h03c, 8'hff);
		rdc("gain readback", 12'h03c, 32'h88);
		chk("tx mute set", tx_mute, 1'b1);
		chk("rx mute set", rx_mute, 1'b1);
		wr(12'h03c, 8'h08);
		chk("tx mute clear", tx_mute, 1'b0);
		chk("rx mute kept", rx_mute, 1'b1);
		xfer(1'b1, 12'h03c, 8'h00, 1'b0);
		chk("rx mute no strobe", rx_mute, 1'b1);
		$display("mute test done");
		wr(12'h040, 8'hff);
		rdc("line readback", 12'h040, 32'h53);
		chk("iir select", iir_sel, 1'b1);
		chk("synth select", synth_sel, 1'b1);
		wr(12'h040, 8'ha0);
		rdc("line loose bits", 12'h040, 32'h0);
		chk("fir select", iir_sel, 1'b0);
		chk("high impedance", synth_sel, 1'b0);
		$display("line test done");
		for (int k = 0; k < 3; k++) begin
			wr(12'h040, {7'h0, k > 0});
			wr(12'h044, {3'h0, k == 2, 4'h0});
			// window is registered one edge behind the written code
			repeat (2) @(posedge pclk);
			chk("ring lower", lo_mv, LO_MV[k]);
			chk("ring upper", hi_mv, HI_MV[k]);
			rdc("line2 readback", 12'h044, {27'h0, k == 2, 4'h0});
		end
		// high bit cleared before the low bit, so code 01 never appears
		wr(12'h044, 8'h00);
		$display("ring test done");
		for (int k = 0; k < 4; k++) begin
			n_exp = (k == 0) ? FAST : (k == 1) ? ETSI : SPARK;
			wr(12'h040, {1'b0, k > 1, 6'h0});
			wr(12'h080, {4'h0, (k > 1) ? 2'h3 : 2'h0, k[0], 1'b1});
			repeat (3) @(posedge pclk);
			chk("loop held", loop_hold, 1'b1);
			rdc("status held", 12'h084, 32'h1);
			wr(12'h080, {4'h0, (k > 1) ? 2'h3 : 2'h0, k[0], 1'b0});
			cyc = 0;
			n_busy = 0;
			while (loop_hold === 1'b1 && cyc < 100) begin
				@(posedge pclk);
				cyc++;
				if (busy === 1'b1) begin
					n_busy++;
				end
			end
			// one edge to enter release, one more to see the drop
			chk("release time", cyc, n_exp + 2);
			chk("release busy", n_busy, n_exp);
		end
		rdc("status idle", 12'h084, 32'h0);
		$display("release test done");
		xfer(1'b0, 12'h100, 8'h00, 1'b1);
		chk("unmapped error", err, 1'b1);
		chk("unmapped data", rd, 32'h0);
		xfer(1'b0, 12'h03d, 8'h00, 1'b1);
		chk("misaligned error", err, 1'b1);
		$display("error test done");
		print_verdict();
	end
endmodule // test_mhr_config_regs
